// ### design/force_err_pkg.sv
package force_err_pkg;
  localparam int unsigned INPUTS = 4;
  localparam logic [3:0] DIGIT_BLANK = 4'h0;
  // error code values, decimal shown as BCD
  localparam logic [11:0] CODE_NONE = 12'h000;
  localparam logic [11:0] CODE_NOT_NORMAL = 12'h003;
  localparam logic [11:0] CODE_OVER = 12'h005;
  localparam logic [11:0] CODE_UNDER = 12'h007;
  localparam logic [11:0] CODE_EXC_SHORT = 12'h010;
  localparam logic [11:0] CODE_SENSE = 12'h011;
  localparam logic [11:0] CODE_SIGNAL = 12'h012;
  localparam logic [11:0] CODE_NO_DATA = 12'h014;
  localparam logic [11:0] CODE_DIGITS = 12'h020;
  localparam logic [11:0] CODE_DIGITS_ALT = 12'h191;
  // restart pulse length
  localparam int unsigned RESTART_NS = 1000;
  localparam int unsigned CLK_NS = 100;
  localparam int unsigned RESTART_CYC = (RESTART_NS + CLK_NS - 1) / CLK_NS;

  // fault flags of one input
  typedef struct packed {
    logic not_normal;
    logic over;
    logic under;
    logic exc_short;
    logic sense;
    logic signal;
    logic no_data;
    logic digits;
    logic digits_alt;
  } fault_s;

  typedef struct packed {
    logic [3:0] digit;
    logic [11:0] code;
  } err_code_s;
endpackage

// ### design/force_error_supervisor.sv
`timescale 1ns/10ps
`default_nettype none
module force_error_supervisor #(
  parameter int unsigned DOUTS = 8,
  parameter int unsigned AOUTS = 4
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // fault inputs, per input A..D, and block-wide (from pins)
  input wire force_err_pkg::fault_s [force_err_pkg::INPUTS-1:0] in_fault_i,
  input wire force_err_pkg::fault_s block_fault_i,
  // normal output demands
  input wire logic [DOUTS-1:0] dout_req_i,
  input wire logic [AOUTS-1:0][15:0] aout_req_i,
  input wire logic process_req_i,
  // restart request
  input wire logic restart_req_i,
  input wire logic lock_active_i,
  input wire logic code_valid_i,
  input wire logic remote_excl_i,
  // outputs
  output logic [DOUTS-1:0] dout_o,
  output logic [AOUTS-1:0][15:0] aout_o,
  output logic in_process_o,
  output force_err_pkg::err_code_s err_code_o,
  output logic error_o,
  output logic restart_o
);
  import force_err_pkg::*;

  // refuse output counts the logic cannot serve
  if (DOUTS < 1 || AOUTS < 1)
  begin : g_bad_cfg
    $error("output counts must be at least one");
  end

  // two-flop synchronisers on pin inputs
  fault_s [INPUTS:0] flt_s1_q;
  fault_s [INPUTS:0] flt_q;
  logic [2:0] ctl_s1_q;
  logic [2:0] ctl_q;

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      flt_s1_q <= '0;
      flt_q <= '0;
      ctl_s1_q <= 3'h0;
      ctl_q <= 3'h0;
    end
    else
    begin
      flt_s1_q <= {block_fault_i, in_fault_i};
      flt_q <= flt_s1_q;
      ctl_s1_q <= {restart_req_i, lock_active_i, code_valid_i};
      ctl_q <= ctl_s1_q;
    end
  end

  // priority encode one fault set to a code
  function automatic logic [11:0] encode(input fault_s f);
    logic [11:0] c;
    c = CODE_NONE;
    if (f.exc_short) c = CODE_EXC_SHORT;
    else if (f.sense) c = CODE_SENSE;
    else if (f.signal) c = CODE_SIGNAL;
    else if (f.over) c = CODE_OVER;
    else if (f.under) c = CODE_UNDER;
    else if (f.no_data) c = CODE_NO_DATA;
    else if (f.not_normal) c = CODE_NOT_NORMAL;
    else if (f.digits) c = CODE_DIGITS;
    else if (f.digits_alt) c = CODE_DIGITS_ALT;
    return c;
  endfunction

  // does a fault set still show the given code
  function automatic logic has_code(input fault_s f, input logic [11:0] c);
    logic h;
    h = 1'b0;
    case (c)
      CODE_NOT_NORMAL: h = f.not_normal;
      CODE_OVER: h = f.over;
      CODE_UNDER: h = f.under;
      CODE_EXC_SHORT: h = f.exc_short;
      CODE_SENSE: h = f.sense;
      CODE_SIGNAL: h = f.signal;
      CODE_NO_DATA: h = f.no_data;
      CODE_DIGITS: h = f.digits;
      CODE_DIGITS_ALT: h = f.digits_alt;
      default: h = 1'b0;
    endcase
    return h;
  endfunction

  logic [INPUTS:0][11:0] src_code;
  logic [INPUTS:0] src_err;
  genvar g;
  generate
    for (g = 0; g <= INPUTS; g++)
    begin : g_src
      assign src_code[g] = encode(flt_q[g]);
      assign src_err[g] = (src_code[g] != CODE_NONE);
    end
  endgenerate

  // pick new code: block-wide first, then input A..D
  err_code_s pick;
  always_comb
  begin
    pick = '{digit: DIGIT_BLANK, code: CODE_NONE};
    if (src_err[INPUTS])
    begin
      pick = '{digit: DIGIT_BLANK, code: src_code[INPUTS]};
    end
    else
    begin
      for (int i = INPUTS - 1; i >= 0; i--)
      begin
        if (src_err[i])
        begin
          pick = '{digit: 4'(i + 1), code: src_code[i]};
        end
      end
    end
  end

  // source of the held code still shows that same fault
  logic held_alive;
  always_comb
  begin
    held_alive = 1'b0;
    if (err_code_o.code != CODE_NONE)
    begin
      if (err_code_o.digit == DIGIT_BLANK)
      begin
        held_alive = has_code(flt_q[INPUTS], err_code_o.code);
      end
      else
      begin
        for (int i = 0; i < INPUTS; i++)
        begin
          if (err_code_o.digit == 4'(i + 1))
          begin
            held_alive = has_code(flt_q[i], err_code_o.code);
          end
        end
      end
    end
  end

  logic any_err;
  assign any_err = |src_err;

  // hold code until its cause clears
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      err_code_o <= '{digit: DIGIT_BLANK, code: CODE_NONE};
      error_o <= 1'b0;
    end
    else
    begin
      if (!held_alive)
      begin
        err_code_o <= pick;
      end
      error_o <= any_err;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dout_o <= '0;
      aout_o <= '0;
      in_process_o <= 1'b0;
    end
    else
    begin
      dout_o <= any_err ? '0 : dout_req_i;
      aout_o <= any_err ? '0 : aout_req_i;
      in_process_o <= process_req_i && !any_err;
    end
  end

  // restart: edge of synced request, lock gated, remote access ignored
  logic restart_prev_q;
  logic [$clog2(RESTART_CYC+1)-1:0] rst_cnt_q;
  logic restart_go;
  assign restart_go = ctl_q[2] && !restart_prev_q && (!ctl_q[1] || ctl_q[0]);

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      restart_prev_q <= 1'b0;
      rst_cnt_q <= '0;
      restart_o <= 1'b0;
    end
    else
    begin
      restart_prev_q <= ctl_q[2];
      if (restart_go && rst_cnt_q == '0)
      begin
        rst_cnt_q <= ($clog2(RESTART_CYC+1))'(RESTART_CYC);
        restart_o <= 1'b1;
      end
      else if (rst_cnt_q != '0)
      begin
        rst_cnt_q <= rst_cnt_q - 1'b1;
        restart_o <= (rst_cnt_q != 1);
      end
    end
  end

  // assertions
  property p_dout_safe;
    @(posedge mclk_i) disable iff (rst_i) any_err |=> (dout_o == '0);
  endproperty
  a_dout_safe: assert property (p_dout_safe) else $error("dout not passive");

  property p_aout_safe;
    @(posedge mclk_i) disable iff (rst_i) any_err |=> (aout_o == '0);
  endproperty
  a_aout_safe: assert property (p_aout_safe) else $error("aout not zero");

  property p_proc_off;
    @(posedge mclk_i) disable iff (rst_i) any_err |=> !in_process_o;
  endproperty
  a_proc_off: assert property (p_proc_off) else $error("in process active on error");

  property p_zero_clear;
    @(posedge mclk_i) disable iff (rst_i) (!any_err && !held_alive) |=> err_code_o.code == 12'h000;
  endproperty
  a_zero_clear: assert property (p_zero_clear) else $error("code not zero");

  property p_exc_code;
    @(posedge mclk_i) disable iff (rst_i)
      (flt_q[INPUTS].exc_short && !held_alive) |=> err_code_o == 16'h0010;
  endproperty
  a_exc_code: assert property (p_exc_code) else $error("excitation code wrong");

  property p_digit_a;
    @(posedge mclk_i) disable iff (rst_i)
      (!held_alive && !src_err[INPUTS] && src_err[0]) |=> err_code_o.digit == 4'h1;
  endproperty
  a_digit_a: assert property (p_digit_a) else $error("input A digit wrong");

  property p_hold;
    @(posedge mclk_i) disable iff (rst_i) held_alive |=> $stable(err_code_o);
  endproperty
  a_hold: assert property (p_hold) else $error("held code changed");

  // length of the current restart pulse, saturating
  logic [$clog2(RESTART_CYC+1)-1:0] pulse_len_q;
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pulse_len_q <= '0;
    end
    else if (!restart_o)
    begin
      pulse_len_q <= '0;
    end
    else if (pulse_len_q != '1)
    begin
      pulse_len_q <= pulse_len_q + 1'b1;
    end
  end

  sequence s_req;
    restart_go && rst_cnt_q == '0;
  endsequence
  sequence s_pulse_end;
    $fell(restart_o);
  endsequence
  property p_restart;
    @(posedge mclk_i) disable iff (rst_i) s_req |=> restart_o;
  endproperty
  a_restart: assert property (p_restart) else $error("restart pulse missing");

  property p_restart_len;
    @(posedge mclk_i) disable iff (rst_i) s_pulse_end |-> (pulse_len_q == RESTART_CYC);
  endproperty
  a_restart_len: assert property (p_restart_len) else $error("restart pulse length wrong");

  property p_locked;
    @(posedge mclk_i) disable iff (rst_i)
      (ctl_q[1] && !ctl_q[0] && !restart_o) |=> !restart_o;
  endproperty
  a_locked: assert property (p_locked) else $error("restart without code");

  property p_excl_ok;
    @(posedge mclk_i) disable iff (rst_i)
      (remote_excl_i && ctl_q[2] && !restart_prev_q && ctl_q[0] && rst_cnt_q == '0) |=> restart_o;
  endproperty
  a_excl_ok: assert property (p_excl_ok) else $error("restart blocked by remote access");

  property p_err_flag;
    @(posedge mclk_i) disable iff (rst_i) any_err |=> error_o;
  endproperty
  a_err_flag: assert property (p_err_flag) else $error("error flag missing");
endmodule
`default_nettype wire

// ### dv/err_read_master.sv
`timescale 1ns/10ps
`default_nettype none
module err_read_master (
  // clock
  input wire logic mclk_i,
  // code from device, read strobe
  input wire force_err_pkg::err_code_s code_i,
  input wire logic rd_i,
  // value read back
  output force_err_pkg::err_code_s rd_data_o
);
  import force_err_pkg::*;
  always_ff @(posedge mclk_i)
  begin
    if (rd_i)
      rd_data_o <= code_i;
  end
endmodule
`default_nettype wire

// ### dv/force_error_supervisor_tb.sv
`timescale 1ns/10ps
`default_nettype none
module force_error_supervisor_tb;
  import force_err_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  fault_s [INPUTS-1:0] in_flt = '0;
  fault_s blk_flt = '0;
  logic [7:0] dout_req = 8'ha5;
  logic [3:0][15:0] aout_req = {4{16'h1234}};
  logic proc_req = 1'b1;
  logic rs_req = 1'b0;
  logic lock = 1'b0;
  logic code_ok = 1'b0;
  logic excl = 1'b1;
  logic rd = 1'b0;
  logic [7:0] dout;
  logic [3:0][15:0] aout;
  logic in_proc;
  logic err;
  logic restart;
  err_code_s code;
  err_code_s rd_code;
  int failures = 0;
  int n_tests = 0;
  logic [11:0] tbl [9] = '{CODE_NOT_NORMAL, CODE_OVER, CODE_UNDER, CODE_EXC_SHORT,
    CODE_SENSE, CODE_SIGNAL, CODE_NO_DATA, CODE_DIGITS, CODE_DIGITS_ALT};

  always #50 mclk_i = ~mclk_i;

  force_error_supervisor #(.DOUTS(8), .AOUTS(4)) i_force_error_supervisor (
    .mclk_i(mclk_i), .rst_i(rst_i), .in_fault_i(in_flt), .block_fault_i(blk_flt),
    .dout_req_i(dout_req), .aout_req_i(aout_req), .process_req_i(proc_req),
    .restart_req_i(rs_req), .lock_active_i(lock), .code_valid_i(code_ok),
    .remote_excl_i(excl), .dout_o(dout), .aout_o(aout), .in_process_o(in_proc),
    .err_code_o(code), .error_o(err), .restart_o(restart));

  err_read_master i_err_read_master (
    .mclk_i(mclk_i), .code_i(code), .rd_i(rd), .rd_data_o(rd_code));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  // outputs after a fault has stood three edges
  task automatic chk_out(input logic [15:0] exp);
    logic bad;
    bad = (exp !== 16'h0000);
    rd = 1'b1;
    step(1);
    rd = 1'b0;
    chk("code", 32'(rd_code), 32'(exp));
    chk("dout", 32'(dout), bad ? 32'h0 : 32'(dout_req));
    chk("aout", 32'(aout !== (bad ? 64'h0 : aout_req)), 32'h0);
    chk("in_process", 32'(in_proc), 32'(!bad));
    chk("error", 32'(err), 32'(bad));
  endtask

  task automatic t_codes;
    for (int k = 0; k <= INPUTS; k++)
    begin
      for (int i = 0; i < 9; i++)
      begin
        if (k < INPUTS)
          in_flt[k] = fault_s'(9'h100 >> i);
        else
          blk_flt = fault_s'(9'h100 >> i);
        step(3);
        chk_out({(k < INPUTS) ? 4'(k + 1) : DIGIT_BLANK, tbl[i]});
        in_flt = '0;
        blk_flt = '0;
        step(3);
        chk_out(16'h0000);
      end
    end
  endtask

  task automatic t_prio;
    in_flt[1].exc_short = 1'b1;
    in_flt[1].over = 1'b1;
    step(3);
    chk_out(16'h2010);
    in_flt = '0;
    step(3);
    in_flt[1].over = 1'b1;
    step(3);
    in_flt[1].exc_short = 1'b1;
    step(3);
    chk_out(16'h2005);
    in_flt = '0;
    in_flt[2].sense = 1'b1;
    blk_flt.under = 1'b1;
    step(3);
    chk_out(16'h0007);
    in_flt = '0;
    blk_flt = '0;
    step(3);
    chk_out(16'h0000);
  endtask

  task automatic t_restart(input logic lk, input logic ok, input logic ex, input int exp);
    int cnt;
    cnt = 0;
    lock = lk;
    code_ok = ok;
    excl = ex;
    step(3);
    rs_req = 1'b1;
    for (int c = 0; c < 30; c++)
    begin
      step(1);
      cnt += int'(restart === 1'b1);
    end
    rs_req = 1'b0;
    step(3);
    chk("restart", 32'(cnt), 32'(exp));
  endtask

  task automatic conclude;
    if (failures == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    step(16);
    rst_i = 1'b0;
    step(4);
    chk_out(16'h0000);
    t_codes();
    t_prio();
    t_restart(1'b0, 1'b0, 1'b0, RESTART_CYC);
    t_restart(1'b1, 1'b0, 1'b1, 0);
    t_restart(1'b1, 1'b1, 1'b1, RESTART_CYC);
    conclude();
  end
endmodule
`default_nettype wire
